// [io_register_space_decode_bench.sv]
// Self-checking bench of the I/O space decoder against a byte-array model
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decode_bench;
  import iorsd_pkg::*;
  logic CLK_SYS = 1'b0, RESET = 1'b1;
  logic req_valid, rsp_valid, rsp_skip, rsp_error;
  iorsd_op_t req_op;
  logic [7:0] req_addr, req_wdata, rsp_rdata, pb_out, pb_dir, pc_out, pc_dir, pd_out, pd_dir;
  logic [2:0] req_bit;
  logic [7:0] t0_set = 8'h00, t1_set = 8'h00, t2_set = 8'h00, pc_set = 8'h00;
  logic [7:0] pin_b = 8'h00, pin_c = 8'h00, pin_d = 8'h00;
  logic [7:0] mem [0:255];
  logic [7:0] bit_addr [5] = '{8'h05, 8'h08, 8'h1f, 8'h20, 8'h1e};
  logic [7:0] ext_addr [3] = '{8'h60, 8'hff, 8'h9a};
  int fail_count = 0, total_checks = 0, seed = 32'hf613ec2f;
  // Clock of 8 ns
  always #4 CLK_SYS = ~CLK_SYS;
  iorsd_core_model core (.clk(CLK_SYS), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata));
  iorsd_decoder uut (.CLK_SYS(CLK_SYS), .RESET(RESET), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_BIT(req_bit), .REQ_WDATA(req_wdata),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_SKIP(rsp_skip),
    .RSP_ERROR(rsp_error), .TMR0_FLAG_SET(t0_set), .TMR1_FLAG_SET(t1_set),
    .TMR2_FLAG_SET(t2_set), .PCHG_FLAG_SET(pc_set), .PIN_B(pin_b), .PIN_C(pin_c),
    .PIN_D(pin_d), .PORT_B_OUT(pb_out), .PORT_B_DIR(pb_dir), .PORT_C_OUT(pc_out),
    .PORT_C_DIR(pc_dir), .PORT_D_OUT(pd_out), .PORT_D_DIR(pd_dir));
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Request through the core model, predict, then compare the answer
  task automatic run(input iorsd_op_t o, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] w);
    bit sent, err, sk;
    logic [7:0] d, rd, m, c;
    int n;
    core.issue(o, a, b, w, sent);
    if (!sent)
      return;
    d = (o >= DATA_SPACE_READ_OP) ? a : a + 8'h20;
    err = (o <= IO_WRITE_OP) ? (a > 8'h3f) :
          (o >= DATA_SPACE_READ_OP) ? (a < 8'h20) : (a > 8'h1f);
    rd = 8'h00;
    sk = 1'b0;
    m = core.wr_mask(d);
    c = core.clr_mask(d);
    if (!err) begin
      case (o)
        IO_READ_OP, DATA_SPACE_READ_OP: rd = mem[d];
        IO_WRITE_OP, DATA_SPACE_WRITE_OP: mem[d] = ((mem[d] & ~m) | (w & m)) & ~(w & c);
        SET_IO_BIT_OP: mem[d] = c[b] ? (mem[d] & ~(8'h01 << b)) : (mem[d] | (m & (8'h01 << b)));
        CLEAR_IO_BIT_OP: mem[d] = mem[d] & ~(m & (8'h01 << b));
        SKIP_IF_IO_BIT_ONE: sk = mem[d][b];
        default: sk = !mem[d][b];
      endcase
    end
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (rsp_valid !== 1'b1 && n < 8);
    if (n >= 8) begin
      fail_count++;
      $display("[FAIL] %0t no answer", $time);
      finish_test();
    end
    // The issue task already spent the first edge after the taking one
    chk(n[7:0], 8'(IORSD_RSP_LAT - 1), "latency");
    chk(rsp_rdata, rd, "read data");
    chk({7'h00, rsp_skip}, {7'h00, sk}, "skip");
    chk({7'h00, rsp_error}, {7'h00, err}, "error");
    // Answer strobe stands one cycle only
    @(negedge CLK_SYS);
    chk({7'h00, rsp_valid}, 8'h00, "pulse length");
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    repeat (10) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RESET = 1'b0;
    for (int i = 0; i < 64; i++)
      run(IO_READ_OP, i[7:0], 3'h0, 8'h00);
    for (int i = 0; i < 64; i++)
      run(i[0] ? IO_WRITE_OP : DATA_SPACE_WRITE_OP, i[7:0] + (i[0] ? 8'h00 : 8'h20),
          3'h0, 8'($random(seed)));
    for (int i = 0; i < 64; i++)
      run(i[0] ? DATA_SPACE_READ_OP : IO_READ_OP, i[7:0] + (i[0] ? 8'h20 : 8'h00),
          3'h0, 8'h00);
    pin_b = 8'($random(seed));
    pin_c = 8'($random(seed));
    pin_d = 8'($random(seed));
    repeat (4) @(negedge CLK_SYS);
    mem[8'h23] = pin_b;
    mem[8'h26] = pin_c & 8'h7f;
    mem[8'h29] = pin_d;
    run(IO_READ_OP, 8'h03, 3'h0, 8'h00);
    run(IO_READ_OP, 8'h06, 3'h0, 8'h00);
    run(DATA_SPACE_READ_OP, 8'h29, 3'h0, 8'h00);
    {t0_set, t1_set, t2_set, pc_set} = {4{8'hff}};
    @(negedge CLK_SYS);
    {t0_set, t1_set, t2_set, pc_set} = 32'h0;
    mem[8'h35] = 8'h07;
    mem[8'h36] = 8'h27;
    mem[8'h37] = 8'h07;
    mem[8'h3b] = 8'h07;
    // Timer 0 event lands in the same cycle as the clearing write
    fork
      run(IO_WRITE_OP, 8'h15, 3'h0, 8'h03);
      begin
        @(negedge CLK_SYS);
        t0_set = 8'h01;
        @(negedge CLK_SYS);
        t0_set = 8'h00;
      end
    join
    mem[8'h35] = mem[8'h35] | 8'h01;
    run(IO_WRITE_OP, 8'h1b, 3'h0, 8'h00);
    run(SET_IO_BIT_OP, 8'h16, 3'h5, 8'h00);
    run(CLEAR_IO_BIT_OP, 8'h17, 3'h1, 8'h00);
    for (int i = 0; i < 4; i++)
      run(IO_READ_OP, {2'b00, IORSD_FLAG_REGS[i]}, 3'h0, 8'h00);
    // Ones on every flag bit clear the whole register
    run(IO_WRITE_OP, 8'h16, 3'h0, 8'hff);
    run(IO_READ_OP, 8'h16, 3'h0, 8'h00);
    for (int i = 0; i < 40; i++)
      run(iorsd_op_t'(3'h2 + i % 4), bit_addr[i % 5], 3'($random(seed)),
          8'h00);
    for (int i = 0; i < 3; i++) begin
      run(DATA_SPACE_WRITE_OP, ext_addr[i], 3'h0, 8'($random(seed)));
      run(DATA_SPACE_READ_OP, ext_addr[i], 3'h0, 8'h00);
      run(iorsd_op_t'(i), ext_addr[i] - 8'h20, 3'h0, 8'h5a);
      run(SET_IO_BIT_OP, ext_addr[i], 3'h1, 8'h00);
    end
    run(DATA_SPACE_WRITE_OP, 8'h10, 3'h0, 8'h33);
    chk(pb_out, mem[8'h25], "port b out");
    chk(pb_dir, mem[8'h24], "port b dir");
    chk(pc_out, mem[8'h28], "port c out");
    chk(pc_dir, mem[8'h27], "port c dir");
    chk(pd_out, mem[8'h2b], "port d out");
    chk(pd_dir, mem[8'h2a], "port d dir");
    finish_test();
  end
endmodule
`default_nettype wire

// [iorsd_core_model.sv]
// Behavioural core model that issues I/O and data-space requests
`timescale 1ns/1ps
`default_nettype none
module iorsd_core_model
  import iorsd_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Request
  output var  logic       req_valid,
  output var  iorsd_op_t  req_op,
  output var  logic [7:0] req_addr,
  output var  logic [2:0] req_bit,
  output var  logic [7:0] req_wdata
);
  // Writable bits of a data-space location
  function automatic logic [7:0] wr_mask(input logic [7:0] d);
    case (d)
      8'h27, 8'h28: return 8'h7f;
      8'h3f:        return 8'h3f;
      8'h43:        return 8'h83;
      8'h44:        return 8'hf3;
      8'h45:        return 8'h0f;
      8'h4d:        return 8'h01;
      8'h24, 8'h25, 8'h2a, 8'h2b, 8'h3e, 8'h40, 8'h41, 8'h42, 8'h46, 8'h47,
      8'h48, 8'h4a, 8'h4b, 8'h4c, 8'h4e: return 8'hff;
      default:      return (d >= 8'h60) ? 8'hff : 8'h00;
    endcase
  endfunction
  // Flag bits that clear on a written one
  function automatic logic [7:0] clr_mask(input logic [7:0] d);
    case (d)
      8'h35, 8'h37, 8'h3b: return 8'h07;
      8'h36:               return 8'h27;
      default:             return 8'h00;
    endcase
  endfunction
  // Idle request lines
  initial begin
    req_valid = 1'b0;
    req_op    = IO_READ_OP;
    req_addr  = 8'h00;
    req_bit   = 3'h0;
    req_wdata = 8'h00;
  end
  // One request held for one cycle; a write to a reserved place is withheld
  task automatic issue(input iorsd_op_t o, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] w, output bit sent);
    logic [7:0] d;
    logic       wr;
    d = (o >= DATA_SPACE_READ_OP) ? a : a + 8'h20;
    wr = (o == IO_WRITE_OP || o == DATA_SPACE_WRITE_OP || o == SET_IO_BIT_OP
          || o == CLEAR_IO_BIT_OP);
    sent = !(wr && d >= 8'h20 && d < 8'h60 && (wr_mask(d) | clr_mask(d)) == 8'h00);
    if (wr && d >= 8'h20 && d < 8'h60)
      w = w & (wr_mask(d) | clr_mask(d));
    if (sent) begin
      @(negedge clk);
      req_valid = 1'b1;
      req_op    = o;
      req_addr  = a;
      req_bit   = b;
      req_wdata = w;
      @(negedge clk);
      req_valid = 1'b0;
      req_addr  = ~req_addr;
      req_wdata = ~req_wdata;
    end
  endtask
endmodule
`default_nettype wire

// [iorsd_decoder.sv]
// Lower I/O register space decoder: direct, single-bit and data-space access
//
// Operation
// - I/O addresses 0x00 to 0x1F take single-bit set and clear from the core.
// - In that range the core may test one bit and skip on one or on zero.
// - Status flags clear on a written one and keep their value on a zero.
// - A single-bit set or clear changes only the addressed bit.
// - Single-bit operations act only on I/O addresses 0x00 to 0x1F.
// - Direct I/O reads and writes address I/O locations 0x00 to 0x3F.
// - Data-space access reaches each I/O register at its address plus 0x20.
// - The direct I/O encoding covers exactly 64 locations.
// - Extended locations 0x60 to 0xFF answer only to data-space access.
`timescale 1ns/1ps
`default_nettype none
module iorsd_decoder
  import iorsd_pkg::*;
#(
  parameter int EXT_WORDS = IORSD_EXT_DEPTH
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  // Core request
  input  wire logic       REQ_VALID,
  input  wire iorsd_op_t  REQ_OP,
  input  wire logic [7:0] REQ_ADDR,
  input  wire logic [2:0] REQ_BIT,
  input  wire logic [7:0] REQ_WDATA,
  // Core answer
  output logic            RSP_VALID,
  output logic      [7:0] RSP_RDATA,
  output logic            RSP_SKIP,
  output logic            RSP_ERROR,
  // Peripheral flag events
  input  wire logic [7:0] TMR0_FLAG_SET,
  input  wire logic [7:0] TMR1_FLAG_SET,
  input  wire logic [7:0] TMR2_FLAG_SET,
  input  wire logic [7:0] PCHG_FLAG_SET,
  // Port pins
  input  wire logic [7:0] PIN_B,
  input  wire logic [7:0] PIN_C,
  input  wire logic [7:0] PIN_D,
  // Port controls
  output logic      [7:0] PORT_B_OUT,
  output logic      [7:0] PORT_B_DIR,
  output logic      [7:0] PORT_C_OUT,
  output logic      [7:0] PORT_C_DIR,
  output logic      [7:0] PORT_D_OUT,
  output logic      [7:0] PORT_D_DIR
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [63:0][7:0] file;
    logic [2:0][7:0]  sync1;
    logic [2:0][7:0]  sync2;
    logic             p1_valid;
    logic             p1_err;
    logic             p1_ext;
    logic             p1_skip;
    logic [7:0]       p1_rdata;
    logic             rsp_valid;
    logic             rsp_err;
    logic             rsp_skip;
    logic [7:0]       rsp_rdata;
  } iorsd_state_t;

  iorsd_state_t    s_q;
  iorsd_state_t    s_d;
  logic            is_io;
  logic            is_bit;
  logic            is_data;
  logic            rd_op;
  logic            skip_op;
  logic            req_ext;
  logic            req_ok;
  logic            io_wr;
  logic [5:0]      idx;
  logic [7:0]      bm;
  logic [7:0]      wd;
  logic [7:0]      st_m;
  logic [7:0]      cur;
  logic [7:0]      old_word;
  logic            skip_hit;
  logic            mem_we;
  logic [7:0]      mem_addr;
  logic [7:0]      mem_rdata;
  logic [3:0][7:0] flag_set;

  // ==========================================================================
  // Parameter check
  if (EXT_WORDS < int'(IORSD_EXT_LAST) - int'(IORSD_EXT_FIRST) + 1) begin : g_ext_bad
    $error("extended storage smaller than the extended window");
  end

  // Read value of one I/O location; pins come from the second sync stage
  function automatic logic [7:0] io_read(input logic [5:0]       i,
                                         input logic [63:0][7:0] f,
                                         input logic [2:0][7:0]  p);
    logic [7:0] v;
    v = f[i] & iorsd_read_mask(i);
    if (i == REG_PORT_B_PINS_IN) begin
      v = p[0];
    end
    if (i == REG_PORT_C_PINS_IN) begin
      v = p[1] & MASK_PORT_C;
    end
    if (i == REG_PORT_D_PINS_IN) begin
      v = p[2];
    end
    return v;
  endfunction

  // ==========================================================================
  // Request decode
  assign is_io   = (REQ_OP == IO_READ_OP) || (REQ_OP == IO_WRITE_OP);
  assign is_bit  = (REQ_OP == SET_IO_BIT_OP) || (REQ_OP == CLEAR_IO_BIT_OP) ||
                   skip_op;
  assign skip_op = (REQ_OP == SKIP_IF_IO_BIT_ONE) || (REQ_OP == SKIP_IF_IO_BIT_ZERO);
  assign is_data = (REQ_OP == DATA_SPACE_READ_OP) || (REQ_OP == DATA_SPACE_WRITE_OP);
  assign rd_op   = (REQ_OP == IO_READ_OP) || (REQ_OP == DATA_SPACE_READ_OP);
  // Extended window is reached by data-space access alone
  assign req_ext = is_data && (REQ_ADDR >= IORSD_EXT_FIRST);
  // Range of each kind of access
  assign req_ok  = is_io  ? (REQ_ADDR <= IORSD_IO_LAST) :
                   is_bit ? (REQ_ADDR <= IORSD_BIT_LAST) :
                            (REQ_ADDR >= IORSD_DATA_OFS);
  // Data-space addresses sit 0x20 above the I/O addresses
  assign idx     = is_data ? 6'(REQ_ADDR - IORSD_DATA_OFS) : REQ_ADDR[5:0];

  // Write data and bit mask; a bit operation touches only its own bit
  assign bm      = is_bit ? (8'h01 << REQ_BIT) : MASK_ALL;
  assign wd      = !is_bit ? REQ_WDATA :
                   (REQ_OP == SET_IO_BIT_OP) ? bm : 8'h00;
  assign st_m    = iorsd_store_mask(idx);
  assign io_wr   = REQ_VALID && req_ok && !req_ext &&
                   ((REQ_OP == IO_WRITE_OP) || (REQ_OP == DATA_SPACE_WRITE_OP) ||
                    (REQ_OP == SET_IO_BIT_OP) || (REQ_OP == CLEAR_IO_BIT_OP));

  // Current contents of the addressed location
  assign cur      = io_read(idx, s_q.file, s_q.sync2);
  assign old_word = s_q.file[idx];
  assign skip_hit = cur[REQ_BIT] == (REQ_OP == SKIP_IF_IO_BIT_ONE);

  // Event inputs in flag register order
  assign flag_set = {PCHG_FLAG_SET, TMR2_FLAG_SET, TMR1_FLAG_SET, TMR0_FLAG_SET};

  // Extended storage access
  assign mem_we   = REQ_VALID && req_ext && (REQ_OP == DATA_SPACE_WRITE_OP);
  assign mem_addr = REQ_ADDR - IORSD_EXT_FIRST;

  iorsd_ext_mem #(
    .DEPTH (EXT_WORDS),
    .AW    (8),
    .DW    (8)
  ) u_ext_mem (
    .clk   (CLK_SYS),
    .reset (RESET),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (REQ_WDATA),
    .rdata (mem_rdata)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Two-stage pin synchronisers
    s_d.sync1 = {PIN_D, PIN_C, PIN_B};
    s_d.sync2 = s_q.sync1;
    // Store only defined bits; reserved locations keep zero
    if (io_wr) begin
      s_d.file[idx] = (s_q.file[idx] & ~(st_m & bm)) | (wd & st_m & bm);
      s_d.file[idx] = s_d.file[idx] & ~(wd & bm & iorsd_w1c_mask(idx));
    end
    // Hardware events set flags after the clear, so a set wins
    for (int k = 0; k < 4; k++) begin
      s_d.file[IORSD_FLAG_REGS[k]] = s_d.file[IORSD_FLAG_REGS[k]] |
        (flag_set[k] & iorsd_w1c_mask(IORSD_FLAG_REGS[k]));
    end
    // First answer stage
    s_d.p1_valid = REQ_VALID;
    s_d.p1_err   = REQ_VALID && !req_ok;
    s_d.p1_ext   = REQ_VALID && req_ext && rd_op;
    s_d.p1_rdata = (REQ_VALID && req_ok && rd_op && !req_ext) ? cur : IORSD_RST_VAL;
    s_d.p1_skip  = REQ_VALID && req_ok && skip_op && skip_hit;
    // Second answer stage drives the answer outputs
    s_d.rsp_valid = s_q.p1_valid;
    s_d.rsp_err   = s_q.p1_err;
    s_d.rsp_skip  = s_q.p1_skip;
    s_d.rsp_rdata = s_q.p1_ext ? mem_rdata : s_q.p1_rdata;
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign RSP_VALID  = s_q.rsp_valid;
  assign RSP_RDATA  = s_q.rsp_rdata;
  assign RSP_SKIP   = s_q.rsp_skip;
  assign RSP_ERROR  = s_q.rsp_err;
  assign PORT_B_OUT = s_q.file[REG_PORT_B_OUTPUT];
  assign PORT_B_DIR = s_q.file[REG_PORT_B_DIRECTION];
  assign PORT_C_OUT = s_q.file[REG_PORT_C_OUTPUT];
  assign PORT_C_DIR = s_q.file[REG_PORT_C_DIRECTION];
  assign PORT_D_OUT = s_q.file[REG_PORT_D_OUTPUT];
  assign PORT_D_DIR = s_q.file[REG_PORT_D_DIRECTION];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // Bit set on a stored bit makes it one
  AST_BIT_SET_STORES:
    assert property (REQ_VALID && REQ_OP == SET_IO_BIT_OP && req_ok && |(st_m & bm)
      |=> s_q.file[$past(idx)][$past(REQ_BIT)])
    else $error("bit set did not store a one");

  // Bit clear on a stored bit makes it zero
  AST_BIT_CLR_STORES:
    assert property (REQ_VALID && REQ_OP == CLEAR_IO_BIT_OP && req_ok && |(st_m & bm)
      |=> !s_q.file[$past(idx)][$past(REQ_BIT)])
    else $error("bit clear did not store a zero");

  // Skip answer follows the tested bit two cycles later
  AST_SKIP_RESULT:
    assert property (REQ_VALID && skip_op && req_ok
      |-> ##2 RSP_VALID && !RSP_ERROR && (RSP_SKIP == $past(skip_hit, 2)))
    else $error("skip answer does not match the tested bit");

  // Writing zero to flags clears none of them
  AST_FLAG_ZERO_KEEPS:
    assert property (io_wr && !is_bit && |iorsd_w1c_mask(idx) && REQ_WDATA == 8'h00
      |=> (s_q.file[$past(idx)] & $past(cur)) == $past(cur))
    else $error("writing zero cleared a flag");

  // Writing ones clears all flags when no event arrives
  AST_FLAG_ONE_CLEARS:
    assert property (io_wr && !is_bit && |iorsd_w1c_mask(idx) &&
      (REQ_WDATA & iorsd_w1c_mask(idx)) == iorsd_w1c_mask(idx) &&
      flag_set == '0 |=> s_q.file[$past(idx)] == 8'h00)
    else $error("writing ones left a flag set");

  // Event in the clearing cycle survives
  AST_FLAG_SET_WINS:
    assert property (io_wr && idx == REG_TIMER0_FLAGS && flag_set[0][0]
      |=> s_q.file[REG_TIMER0_FLAGS][0])
    else $error("flag event lost against a clear");

  // Single-bit operation leaves the other bits alone
  AST_BIT_OP_LOCAL:
    assert property (io_wr && is_bit && flag_set == '0
      |=> ((s_q.file[$past(idx)] ^ $past(old_word)) & ~$past(bm)) == 8'h00)
    else $error("bit operation disturbed another bit");

  // Bit operations beyond 0x1F change nothing and report an error
  AST_BIT_RANGE_NO_WRITE:
    assert property (REQ_VALID && is_bit && REQ_ADDR > IORSD_BIT_LAST && flag_set == '0
      |=> s_q.file == $past(s_q.file))
    else $error("bit operation above its range wrote a register");

  AST_BIT_RANGE_ERROR:
    assert property (REQ_VALID && is_bit && REQ_ADDR > IORSD_BIT_LAST
      |-> ##2 RSP_VALID && RSP_ERROR)
    else $error("bit operation above its range not refused");

  // Direct read inside the window returns the location
  AST_IO_READ_WINDOW:
    assert property (REQ_VALID && REQ_OP == IO_READ_OP && REQ_ADDR <= IORSD_IO_LAST
      |-> ##2 RSP_VALID && !RSP_ERROR && RSP_RDATA == $past(cur, 2))
    else $error("direct read answered wrongly");

  // Data-space write lands 0x20 lower in the I/O window
  AST_DATA_OFFSET:
    assert property (REQ_VALID && REQ_OP == DATA_SPACE_WRITE_OP &&
      REQ_ADDR == IORSD_DATA_OFS + 8'(REG_GENERAL_PURPOSE_0)
      |=> s_q.file[REG_GENERAL_PURPOSE_0] == $past(REQ_WDATA))
    else $error("data-space write missed its I/O register");

  // Direct access beyond 64 locations is refused
  AST_IO_ENCODING_LIMIT:
    assert property (REQ_VALID && is_io && REQ_ADDR > IORSD_IO_LAST
      |-> ##2 RSP_VALID && RSP_ERROR && RSP_RDATA == 8'h00)
    else $error("direct access beyond the window not refused");

  // Extended storage is written by data-space stores alone
  AST_EXT_DATA_ONLY:
    assert property (mem_we |-> REQ_OP == DATA_SPACE_WRITE_OP &&
      REQ_ADDR >= IORSD_EXT_FIRST)
    else $error("extended storage written by a non data-space access");

  // Reserved locations read zero
  AST_RESERVED_READS_ZERO:
    assert property (REQ_VALID && rd_op && req_ok && !req_ext &&
      iorsd_read_mask(idx) == 8'h00 |-> ##2 RSP_RDATA == 8'h00)
    else $error("reserved location read nonzero");

  // Reserved locations ignore writes
  AST_RESERVED_WRITE_IGNORED:
    assert property (io_wr && iorsd_read_mask(idx) == 8'h00 && flag_set == '0
      |=> s_q.file == $past(s_q.file))
    else $error("write to a reserved location changed state");

endmodule
`default_nettype wire

// [iorsd_ext_mem.sv]
// Storage of the extended I/O locations with a registered read port
`timescale 1ns/1ps
`default_nettype none
module iorsd_ext_mem #(
  parameter int DEPTH = 160,
  parameter int AW    = 8,
  parameter int DW    = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } iorsd_mem_state_t;

  iorsd_mem_state_t s_q;
  iorsd_mem_state_t s_d;

  // ==========================================================================
  // Parameter check
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_depth_bad
    $error("memory depth does not fit the address width");
  end

  // Read returns the old word on a write to the same address
  always_comb begin
    s_d = s_q;
    s_d.rdata = (int'(addr) < DEPTH) ? s_q.mem[addr] : '0;
    if (we && int'(addr) < DEPTH) begin
      s_d.mem[addr] = wdata;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

endmodule
`default_nettype wire

// [iorsd_pkg.sv]
// Constants, operation codes and register masks of the I/O space decoder
package iorsd_pkg;

  // ==========================================================================
  // Core operations
  typedef enum logic [2:0] {
    IO_READ_OP          = 3'h0,
    IO_WRITE_OP         = 3'h1,
    SET_IO_BIT_OP       = 3'h2,
    CLEAR_IO_BIT_OP     = 3'h3,
    SKIP_IF_IO_BIT_ONE  = 3'h4,
    SKIP_IF_IO_BIT_ZERO = 3'h5,
    DATA_SPACE_READ_OP  = 3'h6,
    DATA_SPACE_WRITE_OP = 3'h7
  } iorsd_op_t;

  // ==========================================================================
  // Address windows
  localparam logic [7:0] IORSD_BIT_LAST  = 8'h1f; // Last bit-accessible address
  localparam logic [7:0] IORSD_IO_LAST   = 8'h3f; // Last direct I/O address
  localparam logic [7:0] IORSD_DATA_OFS  = 8'h20; // Data-space offset of I/O
  localparam logic [7:0] IORSD_EXT_FIRST = 8'h60; // First extended address
  localparam logic [7:0] IORSD_EXT_LAST  = 8'hff; // Last extended address
  localparam int         IORSD_EXT_DEPTH = 160;   // Extended locations
  localparam logic [7:0] IORSD_RST_VAL   = 8'h00; // Reset value of every register
  localparam int         IORSD_RSP_LAT   = 2;     // Request to answer, cycles

  // ==========================================================================
  // Register offsets in the I/O window
  localparam logic [5:0] REG_PORT_B_PINS_IN     = 6'h03;
  localparam logic [5:0] REG_PORT_B_DIRECTION   = 6'h04;
  localparam logic [5:0] REG_PORT_B_OUTPUT      = 6'h05;
  localparam logic [5:0] REG_PORT_C_PINS_IN     = 6'h06;
  localparam logic [5:0] REG_PORT_C_DIRECTION   = 6'h07;
  localparam logic [5:0] REG_PORT_C_OUTPUT      = 6'h08;
  localparam logic [5:0] REG_PORT_D_PINS_IN     = 6'h09;
  localparam logic [5:0] REG_PORT_D_DIRECTION   = 6'h0a;
  localparam logic [5:0] REG_PORT_D_OUTPUT      = 6'h0b;
  localparam logic [5:0] REG_TIMER0_FLAGS       = 6'h15;
  localparam logic [5:0] REG_TIMER1_FLAGS       = 6'h16;
  localparam logic [5:0] REG_TIMER2_FLAGS       = 6'h17;
  localparam logic [5:0] REG_PIN_CHANGE_FLAGS   = 6'h1b;
  localparam logic [5:0] REG_GENERAL_PURPOSE_0  = 6'h1e;
  localparam logic [5:0] REG_NVM_CONTROL        = 6'h1f;
  localparam logic [5:0] REG_EEPROM_DATA        = 6'h20;
  localparam logic [5:0] REG_EEPROM_ADDR_LOW    = 6'h21;
  localparam logic [5:0] REG_EEPROM_ADDR_HIGH   = 6'h22;
  localparam logic [5:0] REG_TIMER_SYNC_CONTROL = 6'h23;
  localparam logic [5:0] REG_TIMER0_CONTROL_A   = 6'h24;
  localparam logic [5:0] REG_TIMER0_CONTROL_B   = 6'h25;
  localparam logic [5:0] REG_TIMER0_COUNT       = 6'h26;
  localparam logic [5:0] REG_TIMER0_COMPARE_A   = 6'h27;
  localparam logic [5:0] REG_TIMER0_COMPARE_B   = 6'h28;
  localparam logic [5:0] REG_GENERAL_PURPOSE_1  = 6'h2a;
  localparam logic [5:0] REG_GENERAL_PURPOSE_2  = 6'h2b;
  localparam logic [5:0] REG_SPI_CONTROL        = 6'h2c;
  localparam logic [5:0] REG_SPI_STATUS         = 6'h2d;
  localparam logic [5:0] REG_SPI_DATA           = 6'h2e;

  // Flag registers in the order of the event ports
  localparam logic [3:0][5:0] IORSD_FLAG_REGS = {REG_PIN_CHANGE_FLAGS,
    REG_TIMER2_FLAGS, REG_TIMER1_FLAGS, REG_TIMER0_FLAGS};

  // ==========================================================================
  // Field masks
  localparam logic [7:0] MASK_ALL       = 8'hff; // Whole byte
  localparam logic [7:0] MASK_PORT_C    = 8'h7f; // Port C has seven bits
  localparam logic [7:0] MASK_NVM_CTRL  = 8'h3f; // Mode, enables and strobes
  localparam logic [7:0] MASK_TSYNC     = 8'h83; // Sync mode and prescaler resets
  localparam logic [7:0] MASK_T0_CTRL_A = 8'hf3; // Compare modes and waveform
  localparam logic [7:0] MASK_T0_CTRL_B = 8'h0f; // Waveform bit and clock select
  localparam logic [7:0] MASK_SPI_WR    = 8'h01; // Double-speed bit
  localparam logic [7:0] MASK_SPI_RD    = 8'hc1; // Status flags and double speed
  localparam logic [7:0] MASK_FLAGS3    = 8'h07; // Three event flags
  localparam logic [7:0] MASK_T1_FLAGS  = 8'h27; // Capture, compares, overflow

  // Bits that a plain write stores
  function automatic logic [7:0] iorsd_store_mask(input logic [5:0] i);
    case (i)
      REG_PORT_B_DIRECTION, REG_PORT_B_OUTPUT, REG_PORT_D_DIRECTION,
      REG_PORT_D_OUTPUT, REG_GENERAL_PURPOSE_0, REG_EEPROM_DATA,
      REG_EEPROM_ADDR_LOW, REG_EEPROM_ADDR_HIGH, REG_TIMER0_COUNT,
      REG_TIMER0_COMPARE_A, REG_TIMER0_COMPARE_B, REG_GENERAL_PURPOSE_1,
      REG_GENERAL_PURPOSE_2, REG_SPI_CONTROL, REG_SPI_DATA: return MASK_ALL;
      REG_PORT_C_DIRECTION, REG_PORT_C_OUTPUT: return MASK_PORT_C;
      REG_NVM_CONTROL:        return MASK_NVM_CTRL;
      REG_TIMER_SYNC_CONTROL: return MASK_TSYNC;
      REG_TIMER0_CONTROL_A:   return MASK_T0_CTRL_A;
      REG_TIMER0_CONTROL_B:   return MASK_T0_CTRL_B;
      REG_SPI_STATUS:         return MASK_SPI_WR;
      default:                return 8'h00;
    endcase
  endfunction

  // Bits that clear when written with one
  function automatic logic [7:0] iorsd_w1c_mask(input logic [5:0] i);
    case (i)
      REG_TIMER0_FLAGS, REG_TIMER2_FLAGS, REG_PIN_CHANGE_FLAGS: return MASK_FLAGS3;
      REG_TIMER1_FLAGS: return MASK_T1_FLAGS;
      default:          return 8'h00;
    endcase
  endfunction

  // Bits that read back; zero marks a reserved location
  function automatic logic [7:0] iorsd_read_mask(input logic [5:0] i);
    case (i)
      REG_PORT_B_PINS_IN, REG_PORT_D_PINS_IN: return MASK_ALL;
      REG_PORT_C_PINS_IN: return MASK_PORT_C;
      REG_SPI_STATUS:     return MASK_SPI_RD;
      default:            return iorsd_store_mask(i) | iorsd_w1c_mask(i);
    endcase
  endfunction

endpackage
